// ---- src/dxb_slave.sv ----
// x16 ddr memory bus slave transaction logic with wishbone control port
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// ==========================================
module dxb_slave
  import dxb_pkg::*;
#(
  parameter int AW = 10,
  parameter logic [15:0] ID0_VAL = 16'h1234, // arbitrary identity value
  parameter logic [15:0] ID1_VAL = 16'h0005  // arbitrary identity value
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_sel_n,
  input wire logic link_clk,
  input wire logic clock_complement,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic strobe_mask_line_in,
  output logic strobe_mask_line_out,
  output logic strobe_mask_line_oe
);
  // ==========================================
  // reset release and pin synchronisers
  logic [1:0] rst_q;
  logic rst_s_n;
  logic [19:0] pin_a;
  logic [19:0] pin_b;
  logic clk_d;
  logic sel_active;
  logic ck;
  logic rise;
  logic fall;
  logic ledge;
  // reset leaves through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_s_n = rst_q[1];

  // two flops on every link pin
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pin_a <= 20'h80000;
      pin_b <= 20'h80000;
      clk_d <= 1'b0;
    end else begin
      pin_a <= {link_sel_n, link_clk, clock_complement,
                strobe_mask_line_in, dq_in};
      pin_b <= pin_a;
      clk_d <= pin_b[18];
    end
  end

  // clock edges count only with select low
  assign sel_active = !pin_b[19];
  assign ck = pin_b[18];
  assign rise = sel_active && ck && !clk_d;
  assign fall = sel_active && !ck && clk_d;
  assign ledge = rise || fall;

  // ==========================================
  // transaction sequencing
  dxb_state_t st;
  logic [47:0] ca;
  logic [47:0] ca_next;
  logic [2:0] byte_cnt;
  logic ca_done;
  logic [28:0] row_q;
  logic [4:0] lat_cnt;
  logic [4:0] lat_load;
  logic refresh_pend;
  logic data_edge;
  logic [15:0] cr0;
  logic [15:0] cr1;

  // new byte joins on the right, bit 7 from line 7
  assign ca_next = {ca[39:0], pin_b[7:0]};
  assign ca_done = st == ST_CA && ledge && byte_cnt == 3'(CA_BYTES - 1);
  assign lat_load = refresh_pend ? {cr0[LAT_MSB:LAT_LSB], 1'b0}
                                 : {1'b0, cr0[LAT_MSB:LAT_LSB]};
  assign data_edge = (st == ST_LAT && rise && lat_cnt == 5'h00)
                   || ((st == ST_RD || st == ST_WR) && ledge);

  // register selector from the command-address
  function automatic logic [1:0] reg_idx(input logic [47:0] c);
    reg_idx = {c[CA_REG_HI], c[CA_REG_LO]};
  endfunction : reg_idx

  // state machine, select high always returns to idle
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st <= ST_IDLE;
    end else if (!sel_active) begin
      st <= ST_IDLE;
    end else begin
      unique case (st)
        ST_IDLE: begin
          st <= (!ck && pin_b[17]) ? ST_CA : ST_END;
        end
        ST_CA: begin
          if (ca_done) begin
            st <= (!ca_next[CA_RW] && ca_next[CA_AS]) ? ST_REGWR
                                                      : ST_LAT;
          end
        end
        ST_LAT: begin
          if (rise && lat_cnt == 5'h00) begin
            st <= ca[CA_RW] ? ST_RD : ST_WR;
          end
        end
        ST_RD: begin
          st <= ST_RD;
        end
        ST_WR: begin
          st <= ST_WR;
        end
        ST_REGWR: begin
          if (fall) begin
            st <= ST_END;
          end
        end
        ST_END: begin
          st <= ST_END;
        end
      endcase
    end
  end

  // command-address capture over six edges
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ca <= 48'h0;
      byte_cnt <= 3'h0;
      row_q <= 29'h0;
    end else if (st == ST_IDLE) begin
      byte_cnt <= 3'h0;
    end else if (st == ST_CA && ledge) begin
      ca <= ca_next;
      byte_cnt <= byte_cnt + 3'h1;
      if (byte_cnt == 3'(ROW_BYTE)) begin
        row_q <= ca_next[28:0];
      end
    end
  end

  // initial latency counter
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      lat_cnt <= 5'h00;
    end else if (ca_done) begin
      lat_cnt <= lat_load;
    end else if (st == ST_LAT && rise && lat_cnt != 5'h00) begin
      lat_cnt <= lat_cnt - 5'h01;
    end
  end

  // ==========================================
  // burst addressing and array
  logic [AW-1:0] addr;
  logic [AW-1:0] start_q;
  logic [AW-1:0] beats;
  logic [AW-1:0] wmask;
  logic lin;
  logic wrap_done;
  logic mem_we;
  logic [15:0] mem_rd;
  logic [15:0] mem [2**AW];

  assign wmask = AW'((16 << cr0[BL_MSB:BL_LSB]) - 1);

  // address walk per data word
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      addr <= '0;
      start_q <= '0;
      beats <= '0;
      lin <= 1'b1;
      wrap_done <= 1'b0;
    end else if (ca_done) begin
      addr <= AW'({row_q, ca_next[2:0]});
      start_q <= AW'({row_q, ca_next[2:0]});
      beats <= '0;
      lin <= ca[CA_BT - 8];
      wrap_done <= 1'b0;
    end else if (data_edge && !ca[CA_AS]) begin
      beats <= beats + 1'b1;
      if (lin || wrap_done) begin
        addr <= addr + 1'b1;
      end else if (cr0[HYB_BIT] && beats == wmask) begin
        addr <= (start_q & ~wmask) + wmask + 1'b1;
        wrap_done <= 1'b1;
      end else begin
        addr <= (addr & ~wmask) | ((addr + 1'b1) & wmask);
      end
    end
  end

  // masked words leave the array alone
  assign mem_we = data_edge && !ca[CA_RW] && !ca[CA_AS]
                && !pin_b[16];
  assign mem_rd = mem[addr];

  // array storage
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[addr] <= pin_b[15:0];
    end
  end

  // ==========================================
  // device registers
  logic [15:0] rv;
  logic [7:0] hi_q;
  logic have_hi;

  // register read mux
  always_comb begin
    unique case (reg_idx(ca))
      2'h0: rv = ID0_VAL;
      2'h1: rv = ID1_VAL;
      2'h2: rv = cr0;
      2'h3: rv = cr1;
    endcase
  end

  // zero-latency register write, upper byte first
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      cr0 <= CR0_RST;
      cr1 <= CR1_RST;
      hi_q <= 8'h00;
      have_hi <= 1'b0;
    end else if (st != ST_REGWR) begin
      have_hi <= 1'b0;
    end else if (rise) begin
      hi_q <= pin_b[7:0];
      have_hi <= 1'b1;
    end else if (fall && have_hi) begin
      if (reg_idx(ca) == 2'h2) begin
        cr0 <= {hi_q, pin_b[7:0]};
      end
      if (reg_idx(ca) == 2'h3) begin
        cr1 <= {hi_q, pin_b[7:0]};
      end
    end
  end

  // ==========================================
  // pin drivers
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      strobe_mask_line_out <= 1'b0;
      strobe_mask_line_oe <= 1'b0;
    end else if (!sel_active) begin
      dq_oe <= 1'b0;
      strobe_mask_line_oe <= 1'b0;
      strobe_mask_line_out <= 1'b0;
    end else if (st == ST_IDLE || st == ST_CA) begin
      strobe_mask_line_out <= ca_done ? 1'b0 : refresh_pend;
      strobe_mask_line_oe <= !(ca_done && !ca_next[CA_RW]
                               && !ca_next[CA_AS]);
    end else if (data_edge && ca[CA_RW]) begin
      dq_oe <= 1'b1;
      strobe_mask_line_out <= rise;
      if (ca[CA_AS]) begin
        dq_out <= {8'h00, rise ? rv[15:8] : rv[7:0]};
      end else begin
        dq_out <= mem_rd;
      end
    end
  end

  // ==========================================
  // wishbone slave: control, status, config readback
  logic [7:0] xfer_cnt;
  logic last_rd;
  logic last_reg;
  logic wb_req;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // one-cycle ack, data captured with it
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        unique case (wb_adr_i)
          WB_CTRL: wb_dat_o <= {31'h0, refresh_pend};
          WB_STAT: wb_dat_o <= {16'h0, xfer_cnt, 5'h00, last_reg,
                                last_rd, sel_active};
          WB_CR0: wb_dat_o <= {16'h0, cr0};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // latency flag written by software at the ack edge
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      refresh_pend <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
                 && wb_adr_i == WB_CTRL && wb_sel_i[0]) begin
      refresh_pend <= wb_dat_i[0];
    end
  end

  // transaction status
  always_ff @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      xfer_cnt <= 8'h00;
      last_rd <= 1'b0;
      last_reg <= 1'b0;
    end else if (ca_done) begin
      xfer_cnt <= xfer_cnt + 8'h01;
      last_rd <= ca_next[CA_RW];
      last_reg <= ca_next[CA_AS];
    end
  end

  // ==========================================
  // assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_s_n);

  a_sel_abort: assert property (!sel_active |=> st == ST_IDLE ##1 !dq_oe)
    else $error("select high did not abort the transaction");
  a_sel_float: assert property (!sel_active ##1 !sel_active
    |-> !dq_oe && !strobe_mask_line_oe)
    else $error("lines driven with select high");
  a_ca_length: assert property (ca_done |=> st != ST_CA)
    else $error("command-address did not end after six edges");
  a_rw_space: assert property ((st == ST_RD |-> ca[CA_RW])
    and (st == ST_REGWR |-> ca[CA_AS] && !ca[CA_RW]))
    else $error("state does not match command decode");
  a_lat_load: assert property (ca_done && !ca_next[CA_AS]
    |=> lat_cnt == $past(lat_load))
    else $error("latency count not loaded");
  a_mask_gate: assert property (st == ST_WR && data_edge && pin_b[16]
    |-> !mem_we)
    else $error("masked word written to array");
  a_rd_strobe: assert property (st == ST_RD && data_edge
    |=> dq_oe && strobe_mask_line_out == $past(rise))
    else $error("read strobe does not follow the clock edge");
  a_wr_release: assert property (st == ST_LAT && $past(st == ST_LAT)
    && !ca[CA_RW] |-> !strobe_mask_line_oe)
    else $error("strobe line still driven in write latency");
  a_cr0_write: assert property (st == ST_REGWR && fall && have_hi
    && reg_idx(ca) == 2'h2 |=> cr0 == {$past(hi_q), $past(pin_b[7:0])})
    else $error("register write bytes misplaced");
  a_wb_ack: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle");
endmodule : dxb_slave

// ---- pkg/dxb_pkg.sv ----
// shared constants and types for the x16 ddr memory bus slave
package dxb_pkg;
  // ==========================================
  // command-address layout
  localparam int CA_BYTES = 6;
  localparam int ROW_BYTE = 3;
  localparam int CA_RW = 47;
  localparam int CA_AS = 46;
  localparam int CA_BT = 45;
  localparam int CA_REG_HI = 24;
  localparam int CA_REG_LO = 0;
  // ==========================================
  // config_register_zero fields and reset values
  localparam int LAT_LSB = 4;
  localparam int LAT_MSB = 7;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 1;
  localparam int HYB_BIT = 2;
  localparam logic [15:0] CR0_RST = 16'h0020;
  localparam logic [15:0] CR1_RST = 16'h0000;
  // ==========================================
  // wishbone register byte offsets
  localparam logic [3:0] WB_CTRL = 4'h0;
  localparam logic [3:0] WB_STAT = 4'h4;
  localparam logic [3:0] WB_CR0 = 4'h8;
  // ==========================================
  // transaction states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CA,
    ST_LAT,
    ST_RD,
    ST_WR,
    ST_REGWR,
    ST_END
  } dxb_state_t;
endpackage : dxb_pkg

// ---- verif/dxb_host_model.sv ----
// host bus master model driving the link side of the slave
`timescale 1ns/1ps
module dxb_host_model (
  input wire logic core_clk,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic strobe_mask_line_out,
  input wire logic strobe_mask_line_oe,
  output logic link_sel_n,
  output logic link_clk,
  output logic clock_complement,
  output logic [15:0] dq_in,
  output logic strobe_mask_line_in
);
  logic [15:0] h_dq;
  logic h_dq_oe;
  logic h_msk;
  logic h_msk_oe;
  logic flt = 1'b0;
  logic [15:0] dq_q;
  logic sm_q;
  logic smoe_q;
  logic [15:0] wdat [16];
  logic wmsk [16];
  logic [15:0] rdat [32];
  logic rstb [32];
  logic ca_stb;
  logic ca_soe;
  // ==========================================
  // wire level: a line nobody drives shows a changing pattern
  assign dq_in = dq_oe ? dq_out : h_dq_oe ? h_dq : {16{flt}};
  assign strobe_mask_line_in = strobe_mask_line_oe ? strobe_mask_line_out
    : h_msk_oe ? h_msk : flt;
  // samples device outputs one cycle late, away from their updates
  always @(posedge core_clk) begin
    flt <= ~flt;
    dq_q <= dq_out;
    sm_q <= strobe_mask_line_out;
    smoe_q <= strobe_mask_line_oe;
  end
  // bus idle: select high, clock low, complement high
  initial begin
    link_sel_n = 1'b1;
    link_clk = 1'b0;
    clock_complement = 1'b1;
    h_dq = 16'h0000;
    h_dq_oe = 1'b0;
    h_msk = 1'b0;
    h_msk_oe = 1'b0;
  end
  // one link half period: data set, then clock edge, centre aligned
  task automatic hedge(input logic [15:0] d, input logic m);
    h_dq <= d;
    h_msk <= m;
    repeat (2) @(posedge core_clk);
    link_clk <= ~link_clk;
    clock_complement <= link_clk;
    repeat (2) @(posedge core_clk);
  endtask : hedge
  // whole transaction; nca below 6 aborts inside command-address
  task automatic trans(input logic [47:0] ca, input int nca,
                       input int lat, input int n, input logic wr);
    int i;
    link_sel_n <= 1'b0;
    h_dq_oe <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (i = 0; i < nca; i++) begin
      hedge({8'hFF, ca[47-8*i -: 8]}, 1'b0);
      if (i == 4) begin
        ca_stb = sm_q;
        ca_soe = smoe_q;
      end
    end
    if (nca == 6) begin
      h_dq_oe <= wr;
      // mask is taken over only once the device has let go of the line
      for (i = 0; i < lat; i++) begin
        hedge(16'h0000, 1'b0);
        h_msk_oe <= wr;
      end
      for (i = 0; i < n + (wr ? 0 : 1); i++) begin
        hedge(wr ? wdat[i] : 16'h0000, wr ? wmsk[i] : 1'b0);
        if (!wr && i > 0) begin
          rdat[i-1] = dq_q;
          rstb[i-1] = sm_q;
        end
      end
    end
    if (link_clk) begin
      hedge(16'h0000, 1'b0);
    end
    link_sel_n <= 1'b1;
    h_dq_oe <= 1'b0;
    h_msk_oe <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : trans
endmodule : dxb_host_model

// ---- verif/test_dxb_slave.sv ----
// self-checking testbench for the x16 ddr memory bus slave
`timescale 1ns/1ps
module test_dxb_slave
  import dxb_pkg::*;
;
  logic core_clk;
  logic rst_n;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [3:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic [3:0] wsel;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic link_sel_n;
  logic link_clk;
  logic clock_complement;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic dq_oe;
  logic smi;
  logic smo;
  logic smoe;
  int fail_count;
  int n_tests;
  logic [31:0] r;
  logic [15:0] eq[$];
  dxb_slave dxb_slave_i (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_sel_n(link_sel_n),
    .link_clk(link_clk), .clock_complement(clock_complement),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .strobe_mask_line_in(smi), .strobe_mask_line_out(smo),
    .strobe_mask_line_oe(smoe));
  dxb_host_model dxb_host_model_i (.core_clk(core_clk), .dq_out(dq_out),
    .dq_oe(dq_oe), .strobe_mask_line_out(smo), .strobe_mask_line_oe(smoe),
    .link_sel_n(link_sel_n), .link_clk(link_clk),
    .clock_complement(clock_complement), .dq_in(dq_in),
    .strobe_mask_line_in(smi));
  // ==========================================
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] wd, output logic [31:0] rd);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= wsel;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (wb_ack_o === 1'b1) break;
    end
    check(32'(k < 20), 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
    @(posedge core_clk);
  endtask : wb
  function automatic logic [47:0] ca(input logic rd, input logic rg,
                                     input logic lin, input logic [31:0] a);
    return {rd, rg, lin, a[31:3], 13'h0000, a[2:0]};
  endfunction : ca
  // link transfer, then both lines must float again
  task automatic go(input logic [47:0] c, input int lat, input int n,
                    input logic wr);
    int i;
    dxb_host_model_i.trans(c, 6, lat, n, wr);
    check(32'({dq_oe, smoe}), 32'h0);
    for (i = 0; i < eq.size(); i++) begin
      check(32'(dxb_host_model_i.rdat[i]), 32'(eq[i]));
      check(32'(dxb_host_model_i.rstb[i]), 32'(!i[0]));
    end
    eq = {};
  endtask : go
  task automatic fill(input logic [15:0] base, input logic [15:0] mk);
    int i;
    for (i = 0; i < 16; i++) begin
      dxb_host_model_i.wdat[i] = base + 16'(i);
      dxb_host_model_i.wmsk[i] = mk[i];
    end
  endtask : fill
  // ==========================================
  // main sequence
  initial begin
    fail_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'h0;
    wsel = 4'hF;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    wb(1'b0, WB_CTRL, 32'h0, r);
    check(r, 32'h0);
    wb(1'b0, WB_CR0, 32'h0, r);
    check(r, 32'h00000020);
    wb(1'b0, 4'hC, 32'h0, r);
    check(r, 32'h0);
    fill(16'hA000, 16'h0000);
    go(ca(1'b0, 1'b0, 1'b1, 32'd0), 4, 16, 1'b1);
    fill(16'hC000, 16'h0000);
    go(ca(1'b0, 1'b0, 1'b1, 32'd1022), 4, 4, 1'b1);
    fill(16'hB000, 16'h000A);
    go(ca(1'b0, 1'b0, 1'b1, 32'd2), 4, 4, 1'b1);
    eq = '{16'hC000, 16'hC001, 16'hC002, 16'hC003,
           16'hB000, 16'hA003, 16'hB002, 16'hA005};
    go(ca(1'b1, 1'b0, 1'b1, 32'd1022), 4, 8, 1'b0);
    check(32'({dxb_host_model_i.ca_stb, dxb_host_model_i.ca_soe}), 32'h1);
    eq = '{16'hA00E, 16'hA00F, 16'hC002, 16'hC003};
    go(ca(1'b1, 1'b0, 1'b0, 32'd14), 4, 4, 1'b0);
    wb(1'b1, WB_CTRL, 32'h1, r);
    wsel = 4'hE;
    wb(1'b1, WB_CTRL, 32'h0, r);
    wsel = 4'hF;
    wb(1'b0, WB_CTRL, 32'h0, r);
    check(r, 32'h00000001);
    eq = '{16'hB002, 16'hA005};
    go(ca(1'b1, 1'b0, 1'b1, 32'd4), 8, 2, 1'b0);
    check(32'({dxb_host_model_i.ca_stb, dxb_host_model_i.ca_soe}), 32'h3);
    eq = '{16'h0000, 16'h0020};
    go(ca(1'b1, 1'b1, 1'b1, 32'h800), 8, 2, 1'b0);
    dxb_host_model_i.trans(ca(1'b1, 1'b0, 1'b1, 32'd0), 2, 0, 0, 1'b0);
    wb(1'b0, WB_STAT, 32'h0, r);
    check(r, 32'h00000706);
    dxb_host_model_i.wdat[0] = 16'h5500;
    dxb_host_model_i.wdat[1] = 16'h5530;
    go(ca(1'b0, 1'b1, 1'b1, 32'h800), 0, 2, 1'b1);
    wb(1'b0, WB_CR0, 32'h0, r);
    check(r, 32'h00000030);
    eq = '{16'hC000, 16'hC001};
    go(ca(1'b1, 1'b0, 1'b1, 32'd1022), 12, 2, 1'b0);
    fill(16'hD000, 16'h0000);
    go(ca(1'b0, 1'b0, 1'b1, 32'd16), 12, 2, 1'b1);
    dxb_host_model_i.wdat[0] = 16'h5500;
    dxb_host_model_i.wdat[1] = 16'h5534;
    go(ca(1'b0, 1'b1, 1'b1, 32'h800), 0, 2, 1'b1);
    wb(1'b0, WB_CR0, 32'h0, r);
    check(r, 32'h00000034);
    // hybrid wrap: one pass round the 16-word group, then on from 16
    eq = '{16'hA00E, 16'hA00F, 16'hC002, 16'hC003, 16'hB000, 16'hA003,
           16'hB002, 16'hA005, 16'hA006, 16'hA007, 16'hA008, 16'hA009,
           16'hA00A, 16'hA00B, 16'hA00C, 16'hA00D, 16'hD000, 16'hD001};
    go(ca(1'b1, 1'b0, 1'b0, 32'd14), 12, 18, 1'b0);
    test_done();
  end
endmodule : test_dxb_slave
